// >>> logic/ckl_keying.v
// Carrier keying decision logic with a classic Wishbone register slave.
// Assumes command, button and jumper pins are asynchronous levels, already
// isolated and level shifted, active high meaning energised, pressed or fitted.
`timescale 1ns/10ps
`default_nettype none

`include "ckl_regs.vh"

module ckl_keying (
   // Clock, reset and enable
   input  wire        CLK_SYS,
   input  wire        RESETN,
   input  wire        CE,

   // Relay command lines
   input  wire        START_LINE,
   input  wire        START_LINE_LOW,
   input  wire        STOP_LINE,
   input  wire        LOW_LEVEL_LINE,

   // Checkback and voice key requests
   input  wire        HIGH_CHECKBACK_KEY,
   input  wire        LOW_CHECKBACK_KEY,
   input  wire        VOICE_KEY_REQ,

   // Front panel buttons
   input  wire        HIGH_TEST_BUTTON,
   input  wire        LOW_TEST_BUTTON,

   // Board jumpers
   input  wire        START_POLARITY_JUMPER,
   input  wire        STOP_POLARITY_JUMPER,
   input  wire        LOWLEVEL_POLARITY_JUMPER,
   input  wire        STOP_PRIORITY_JUMPER,
   input  wire        SINGLE_LINE_MODE_JUMPER,

   // Transmitter keys
   output reg         HIGH_LEVEL_KEY,
   output reg         ANY_TX_KEY,
   output reg         VOICE_KEY,

   // Indicators
   output reg         HIGH_POWER_INDICATOR,
   output reg         LOW_POWER_INDICATOR,
   output reg         VOICE_INDICATOR,

   // Wishbone slave
   input  wire        WB_CYC_I,
   input  wire        WB_STB_I,
   input  wire        WB_WE_I,
   input  wire [7:0]  WB_ADR_I,
   input  wire [3:0]  WB_SEL_I,
   input  wire [31:0] WB_DAT_I,
   output reg  [31:0] WB_DAT_O,
   output reg         WB_ACK_O
);

   // ****************************************************************************
   // Pin synchronisers
   // ****************************************************************************

   wire [`CKL_PIN_W-1:0] pin_raw;
   wire [`CKL_PIN_W-1:0] pin_sync;

   assign pin_raw = {
      SINGLE_LINE_MODE_JUMPER,
      STOP_PRIORITY_JUMPER,
      LOWLEVEL_POLARITY_JUMPER,
      STOP_POLARITY_JUMPER,
      START_POLARITY_JUMPER,
      LOW_TEST_BUTTON,
      HIGH_TEST_BUTTON,
      VOICE_KEY_REQ,
      LOW_CHECKBACK_KEY,
      HIGH_CHECKBACK_KEY,
      LOW_LEVEL_LINE,
      STOP_LINE,
      START_LINE_LOW,
      START_LINE
   };

   ckl_sync2 #(
      .W (`CKL_PIN_W)
   ) u_sync (
      .clk   (CLK_SYS),
      .rst_n (RESETN),
      .ce    (CE),
      .d     (pin_raw),
      .q     (pin_sync)
   );

   wire start_line_s;
   wire start_low_s;
   wire stop_line_s;
   wire low_line_s;
   wire hi_cb_s;
   wire lo_cb_s;
   wire voice_req_s;
   wire hi_button_s;
   wire lo_button_s;
   wire start_pol_normal;
   wire stop_pol_normal;
   wire low_pol_normal;
   wire prio_fitted;
   wire single_line;

   assign start_line_s     = pin_sync[0];
   assign start_low_s      = pin_sync[1];
   assign stop_line_s      = pin_sync[2];
   assign low_line_s       = pin_sync[3];
   assign hi_cb_s          = pin_sync[4];
   assign lo_cb_s          = pin_sync[5];
   assign voice_req_s      = pin_sync[6];
   assign hi_button_s      = pin_sync[7];
   assign lo_button_s      = pin_sync[8];
   assign start_pol_normal = pin_sync[9];
   assign stop_pol_normal  = pin_sync[10];
   assign low_pol_normal   = pin_sync[11];
   assign prio_fitted      = pin_sync[12];
   assign single_line      = pin_sync[13];

   // ****************************************************************************
   // Software test control
   // ****************************************************************************

   reg [`CKL_CTRL_W-1:0] ctrl_reg;
   wire                  sw_hi_test;
   wire                  sw_lo_test;

   assign sw_hi_test = ctrl_reg[`CKL_CTRL_HI_TEST];
   assign sw_lo_test = ctrl_reg[`CKL_CTRL_LO_TEST];

   // ****************************************************************************
   // Command decode
   // ****************************************************************************

   reg carrier_start_request;
   reg carrier_stop_request;
   reg low_level_command;

   // A jumper reads high in its normal position; an inverted jumper makes the
   // de-energised line the active state.
   always @* begin
      if (single_line) begin
         // The line driven high wins outright, so a momentary overlap of both
         // sense inputs while the line slews can never yield a stop.
         carrier_start_request = start_line_s;
         carrier_stop_request  = start_low_s & ~start_line_s;
      end else begin
         carrier_start_request = start_line_s ^ ~start_pol_normal;
         carrier_stop_request  = stop_line_s ^ ~stop_pol_normal;
      end
      low_level_command = low_line_s ^ ~low_pol_normal;
   end

   // ****************************************************************************
   // Keying decision
   // ****************************************************************************

   reg hi_request;
   reg hi_key_next;
   reg lo_key_next;
   reg voice_key_next;
   reg any_key_next;

   always @* begin
      // Requests that the stop priority jumper may block.
      hi_request = carrier_start_request | hi_cb_s;
      if (prio_fitted && carrier_stop_request) begin
         hi_request = 1'h0;
      end
      // Manual high-level tests bypass the command lines entirely.
      hi_key_next = hi_request | hi_button_s | sw_hi_test;
      lo_key_next = low_level_command | lo_cb_s | lo_button_s | sw_lo_test;
      voice_key_next = voice_req_s;
      if (carrier_stop_request) begin
         voice_key_next = 1'h0;
      end
      if (hi_key_next || lo_key_next) begin
         voice_key_next = 1'h0;
      end
      any_key_next = hi_key_next | lo_key_next | voice_key_next;
   end

   // ****************************************************************************
   // Registered outputs
   // ****************************************************************************

   reg lo_key_reg;

   // The outputs lag the pins by three clocks; at this clock that is far
   // below any relay contact time, and it keeps glitches off the keys.
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         HIGH_LEVEL_KEY       <= 1'h0;
         ANY_TX_KEY           <= 1'h0;
         VOICE_KEY            <= 1'h0;
         HIGH_POWER_INDICATOR <= 1'h0;
         LOW_POWER_INDICATOR  <= 1'h0;
         VOICE_INDICATOR      <= 1'h0;
         lo_key_reg           <= 1'h0;
      end else if (CE) begin
         HIGH_LEVEL_KEY       <= hi_key_next;
         ANY_TX_KEY           <= any_key_next;
         VOICE_KEY            <= voice_key_next;
         HIGH_POWER_INDICATOR <= hi_key_next;
         LOW_POWER_INDICATOR  <= lo_key_next;
         VOICE_INDICATOR      <= voice_key_next;
         lo_key_reg           <= lo_key_next;
      end
   end

   // ****************************************************************************
   // Wishbone slave
   // ****************************************************************************

   wire        wb_req;
   wire        hit_ctrl;
   wire        hit_stat;
   wire [31:0] stat_word;

   assign wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign hit_ctrl = (WB_ADR_I == `CKL_CTRL_ADDR);
   assign hit_stat = (WB_ADR_I == `CKL_STAT_ADDR);

   assign stat_word = {
      {(32 - `CKL_ST_W){1'h0}},
      prio_fitted,
      single_line,
      low_level_command,
      carrier_stop_request,
      carrier_start_request,
      ANY_TX_KEY,
      VOICE_KEY,
      lo_key_reg,
      HIGH_LEVEL_KEY
   };

   // Every access, mapped or not, is answered one clock after it is seen.
   // Unmapped reads return zero and unmapped or status writes are dropped.
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         WB_ACK_O <= 1'h0;
         WB_DAT_O <= 32'h00000000;
         ctrl_reg <= `CKL_CTRL_RST;
      end else if (CE) begin
         WB_ACK_O <= wb_req;
         if (wb_req && WB_WE_I && hit_ctrl && WB_SEL_I[0]) begin
            ctrl_reg <= WB_DAT_I[`CKL_CTRL_W-1:0];
         end
         if (wb_req && !WB_WE_I) begin
            if (hit_ctrl) begin
               WB_DAT_O <= {{(32 - `CKL_CTRL_W){1'h0}}, ctrl_reg};
            end else if (hit_stat) begin
               WB_DAT_O <= stat_word;
            end else begin
               WB_DAT_O <= 32'h00000000;
            end
         end
      end
   end

endmodule

`default_nettype wire

// >>> logic/ckl_regs.vh
// Constants of the carrier keying logic: register offsets, field positions, resets.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
//
// Contract
// - Start request follows the start line, or its inverse when start polarity is inverted.
// - Stop request follows the stop line, or its inverse when stop polarity is inverted.
// - Low-level request follows its line, or its inverse when that polarity is inverted.
// - A carrier start request asserts the high-level key output.
// - Low button starts a low-level test; high button forces high-level keying regardless.
// - High checkback, low checkback and voice key inputs each key their power level.
// - Outputs are high-level key, voice key and any key for low, voice or high.
// - Separate indicators light for high-level, low-level and voice keying.
// - With priority jumper fitted, stop blocks high-level key; otherwise start wins.
// - An active stop always blocks the voice key output.
// - Voice key is suppressed while the high-level or low-level key is active.
// - Single-line mode: high starts and inhibits stop, low stops, open gives neither.
`ifndef CKL_REGS_VH
`define CKL_REGS_VH

// ****************************************************************************
// Register map
// ****************************************************************************
`define CKL_ADR_W         8
`define CKL_CTRL_ADDR     8'h00
`define CKL_STAT_ADDR     8'h04
`define CKL_CTRL_RST      2'h0

// ****************************************************************************
// Control fields
// ****************************************************************************
`define CKL_CTRL_HI_TEST  0
`define CKL_CTRL_LO_TEST  1
`define CKL_CTRL_W        2

// ****************************************************************************
// Status fields
// ****************************************************************************
`define CKL_ST_HI_KEY     0
`define CKL_ST_LO_KEY     1
`define CKL_ST_VOICE_KEY  2
`define CKL_ST_ANY_KEY    3
`define CKL_ST_START      4
`define CKL_ST_STOP       5
`define CKL_ST_LOW_CMD    6
`define CKL_ST_SINGLE     7
`define CKL_ST_PRIO       8
`define CKL_ST_W          9

// ****************************************************************************
// Synchronised pin vector
// ****************************************************************************
`define CKL_PIN_W         14

`endif

// >>> logic/ckl_sync2.v
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent slow level; no word coherence is given.
`timescale 1ns/10ps
`default_nettype none

module ckl_sync2 #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   input  wire         ce,
   // Levels
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   // Only the second stage is read by anything else.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= {W{1'h0}};
         sync_reg <= {W{1'h0}};
      end else if (ce) begin
         meta_reg <= d;
         sync_reg <= meta_reg;
      end
   end

   assign q = sync_reg;

endmodule

`default_nettype wire

// >>> sim/ckl_checker.sv
// Checker for the keying outputs and the bus answer of the keying block.
// Assumes CE is held high, so a pin level reaches the outputs after three edges.
`timescale 1ns/10ps
`default_nettype none
module ckl_checker (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESETN,
   // Command lines and jumpers
   input wire logic START_LINE,
   input wire logic START_LINE_LOW,
   input wire logic STOP_LINE,
   input wire logic START_POLARITY_JUMPER,
   input wire logic STOP_POLARITY_JUMPER,
   input wire logic SINGLE_LINE_MODE_JUMPER,
   input wire logic STOP_PRIORITY_JUMPER,
   // High-level requests
   input wire logic HIGH_CHECKBACK_KEY,
   input wire logic HIGH_TEST_BUTTON,
   // Bus handshake
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   // Keys and indicators
   input wire logic HIGH_LEVEL_KEY,
   input wire logic ANY_TX_KEY,
   input wire logic VOICE_KEY,
   input wire logic HIGH_POWER_INDICATOR,
   input wire logic LOW_POWER_INDICATOR,
   input wire logic VOICE_INDICATOR
);
   // ************
   // Helpers
   // ************
   // Pin history from before a reset must not be held against the outputs.
   logic [1:0] age_reg;
   wire armed = (age_reg == 2'h3);
   wire sl = SINGLE_LINE_MODE_JUMPER;
   wire start_w = sl ? START_LINE : ~(START_LINE ^ START_POLARITY_JUMPER);
   wire stop_w = sl ? (START_LINE_LOW & ~START_LINE) : ~(STOP_LINE ^ STOP_POLARITY_JUMPER);
   wire hcb_w = HIGH_CHECKBACK_KEY & ~(STOP_PRIORITY_JUMPER & stop_w);
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         age_reg <= 2'h0;
      else if (!armed)
         age_reg <= age_reg + 2'h1;
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   sequence taken_s; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
   sequence pulse_s; WB_ACK_O ##1 !WB_ACK_O; endsequence
   // ************
   // Assertions
   // ************
   start_key_a: assert property (armed && $past(start_w & ~stop_w, 3) |-> HIGH_LEVEL_KEY)
      else $error("start request did not key high level");
   start_prio_a: assert property (armed && $past(start_w & ~STOP_PRIORITY_JUMPER, 3) |-> HIGH_LEVEL_KEY)
      else $error("start lost to stop without priority jumper");
   checkback_a: assert property (armed && $past(hcb_w, 3) |-> HIGH_LEVEL_KEY)
      else $error("high checkback did not key high level");
   button_a: assert property (armed && $past(HIGH_TEST_BUTTON, 3) |-> HIGH_LEVEL_KEY)
      else $error("high test button did not key high level");
   stop_voice_a: assert property (armed && VOICE_KEY |-> !$past(stop_w, 3))
      else $error("voice keyed during stop");
   any_key_a: assert property (ANY_TX_KEY == (HIGH_LEVEL_KEY | VOICE_KEY | LOW_POWER_INDICATOR))
      else $error("any key differs from its sources");
   indicators_a: assert property (HIGH_POWER_INDICATOR == HIGH_LEVEL_KEY && VOICE_INDICATOR == VOICE_KEY)
      else $error("indicator differs from its key");
   voice_excl_a: assert property (VOICE_KEY |-> !HIGH_LEVEL_KEY && !LOW_POWER_INDICATOR)
      else $error("voice keyed beside a power key");
   ack_pulse_a: assert property (taken_s |=> pulse_s)
      else $error("bus answer not a one-cycle pulse");
endmodule
bind ckl_keying ckl_checker chk (
   .CLK_SYS                 (CLK_SYS),
   .RESETN                  (RESETN),
   .START_LINE              (START_LINE),
   .START_LINE_LOW          (START_LINE_LOW),
   .STOP_LINE               (STOP_LINE),
   .START_POLARITY_JUMPER   (START_POLARITY_JUMPER),
   .STOP_POLARITY_JUMPER    (STOP_POLARITY_JUMPER),
   .SINGLE_LINE_MODE_JUMPER (SINGLE_LINE_MODE_JUMPER),
   .STOP_PRIORITY_JUMPER    (STOP_PRIORITY_JUMPER),
   .HIGH_CHECKBACK_KEY      (HIGH_CHECKBACK_KEY),
   .HIGH_TEST_BUTTON        (HIGH_TEST_BUTTON),
   .WB_CYC_I                (WB_CYC_I),
   .WB_STB_I                (WB_STB_I),
   .WB_ACK_O                (WB_ACK_O),
   .HIGH_LEVEL_KEY          (HIGH_LEVEL_KEY),
   .ANY_TX_KEY              (ANY_TX_KEY),
   .VOICE_KEY               (VOICE_KEY),
   .HIGH_POWER_INDICATOR    (HIGH_POWER_INDICATOR),
   .LOW_POWER_INDICATOR     (LOW_POWER_INDICATOR),
   .VOICE_INDICATOR         (VOICE_INDICATOR)
);
`default_nettype wire

// >>> sim/ckl_relay_model.sv
// Relay side: turns start, stop and low-level commands into contact levels.
// Assumes commands change just after a clock edge; slow adds one cycle of lag.
`timescale 1ns/10ps
`default_nettype none
module ckl_relay_model (
   // Clock and mode
   input  wire logic clk,
   input  wire logic slow,
   input  wire logic single,
   // Commands and polarities
   input  wire logic start_c,
   input  wire logic stop_c,
   input  wire logic low_c,
   input  wire logic pol_start,
   input  wire logic pol_stop,
   input  wire logic pol_low,
   // Contact levels
   output wire logic start_line,
   output wire logic start_low,
   output wire logic stop_line,
   output wire logic low_line
);
   // ************
   // Contacts
   // ************
   // Unused lines toggle so that an ignored input can never pass by luck.
   logic       tog_reg = 1'h0;
   logic [3:0] lag_reg = 4'h0;
   logic [3:0] out_reg = 4'h0;
   logic [3:0] now_w;
   assign {start_line, start_low, stop_line, low_line} = out_reg;
   always_comb begin
      if (single)
         now_w = {start_c, stop_c & ~start_c, tog_reg, ~(low_c ^ pol_low)};
      else
         now_w = {~(start_c ^ pol_start), tog_reg, ~(stop_c ^ pol_stop), ~(low_c ^ pol_low)};
   end
   always @(posedge clk) begin
      tog_reg <= ~tog_reg;
      lag_reg <= now_w;
      out_reg <= slow ? lag_reg : now_w;
   end
endmodule
`default_nettype wire

// >>> sim/ckl_keying_tb.sv
// Self-checking bench for the carrier keying logic.
// Assumes the relay model drives the command lines and CE stays high.
`timescale 1ns/10ps
`default_nettype none
module ckl_keying_tb;
   logic clk = 1'h0, rst_n = 1'h0, slow = 1'h0, chk = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
   logic sl = 1'h0, sc = 1'h0, pc = 1'h0, lc = 1'h0, ps = 1'h1, pp = 1'h1, pl = 1'h1, prio = 1'h0;
   logic hcb = 1'h0, lcb = 1'h0, vrq = 1'h0, hb = 1'h0, lb = 1'h0, swh = 1'h0, swl = 1'h0;
   logic hi, lo, vo, sp;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, v;
   logic [31:0] exp_q[$];
   wire [31:0] rdat;
   wire ack, hk, ak, vk, hi_i, lo_i, v_i, s_l, s_lo, p_l, l_l;
   integer n_errors = 0, n_compared = 0, cycles = 0, seed = 32'h51C82242, i;
   ckl_relay_model rly (.clk(clk), .slow(slow), .single(sl), .start_c(sc), .stop_c(pc), .low_c(lc),
      .pol_start(ps), .pol_stop(pp), .pol_low(pl), .start_line(s_l), .start_low(s_lo),
      .stop_line(p_l), .low_line(l_l));
   ckl_keying dut (.CLK_SYS(clk), .RESETN(rst_n), .CE(1'h1), .START_LINE(s_l), .START_LINE_LOW(s_lo),
      .STOP_LINE(p_l), .LOW_LEVEL_LINE(l_l), .HIGH_CHECKBACK_KEY(hcb), .LOW_CHECKBACK_KEY(lcb),
      .VOICE_KEY_REQ(vrq), .HIGH_TEST_BUTTON(hb), .LOW_TEST_BUTTON(lb), .START_POLARITY_JUMPER(ps),
      .STOP_POLARITY_JUMPER(pp), .LOWLEVEL_POLARITY_JUMPER(pl), .STOP_PRIORITY_JUMPER(prio),
      .SINGLE_LINE_MODE_JUMPER(sl), .HIGH_LEVEL_KEY(hk), .ANY_TX_KEY(ak), .VOICE_KEY(vk),
      .HIGH_POWER_INDICATOR(hi_i), .LOW_POWER_INDICATOR(lo_i), .VOICE_INDICATOR(v_i), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack));
   initial begin
      forever #20 clk = ~clk;
   end
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task final_report;
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      @(posedge clk);
      while (ack !== 1'h1) @(posedge clk);
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask
   // Seven edges cover the model lag, two sync stages and the output stage.
   task step(input logic [12:0] p);
      @(posedge clk);
      {sl, sc, pc, lc, ps, pp, pl, prio, hcb, lcb, vrq, hb, lb} <= p;
      repeat (7) @(posedge clk);
      sp = sl ? (pc & ~sc) : pc;
      hi = hb | swh | ((sc | hcb) & ~(prio & sp));
      lo = lc | lcb | lb | swl;
      vo = vrq & ~sp & ~hi & ~lo;
      exp_q.push_back({26'h0, hi, hi | lo | vo, vo, hi, lo, vo});
      chk <= 1'h1;
      @(posedge clk);
      chk <= 1'h0;
      exp_q.push_back({23'h0, prio, sl, lc, sp, sc, hi | lo | vo, vo, lo, hi});
      wb(1'h0, 8'h04, 4'hF, 32'h0);
   endtask
   always @(posedge clk) begin
      if (chk) check("keys", {26'h0, hk, ak, vk, hi_i, lo_i, v_i}, exp_q.pop_front());
      if (ack === 1'h1 && we === 1'h0) check("read", rdat, exp_q.pop_front());
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_errors++;
         final_report;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      for (i = 0; i < 3; i++) step(13'h11C4 | ((13'h0800 >> i) & 13'h0C00));
      $display("single-line test done");
      for (i = 0; i < 60; i++) begin
         slow <= i[0];
         v = $random(seed);
         step(v[12:0]);
      end
      $display("random test done");
      wb(1'h1, 8'h00, 4'hF, 32'hFFFFFFFF);
      swh = 1'h1;
      swl = 1'h1;
      wb(1'h1, 8'h00, 4'h0, 32'h0);
      wb(1'h1, 8'h10, 4'hF, 32'hFFFFFFFF);
      wb(1'h1, 8'h04, 4'hF, 32'h0);
      step(13'h01C4);
      exp_q.push_back(32'h3);
      wb(1'h0, 8'h00, 4'hF, 32'h0);
      exp_q.push_back(32'h0);
      wb(1'h0, 8'h10, 4'hF, 32'h0);
      $display("software test done");
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      swh = 1'h0;
      swl = 1'h0;
      step(13'h01C4);
      exp_q.push_back(32'h0);
      wb(1'h0, 8'h00, 4'hF, 32'h0);
      $display("reset test done");
      final_report;
   end
endmodule
`default_nettype wire
